// File: cms_pkg.sv
package cms_pkg;

  localparam int unsigned CLK_FREQ_HZ      = 25_000_000;
  // power-on reset: longest time, rounds down
  localparam int unsigned POR_TIME_US      = 50;
  localparam int unsigned POR_CYCLES       = (POR_TIME_US * (CLK_FREQ_HZ / 1_000_000));
  // reconfiguration budget: longest time, rounds down
  localparam int unsigned RECFG_TIME_MS    = 40;
  localparam int unsigned RECFG_CYCLES     = RECFG_TIME_MS * (CLK_FREQ_HZ / 1000);
  // source power-settle delay, kept by the memory device
  localparam int unsigned SRC_SETTLE_MS    = 200;
  localparam int unsigned SRC_SETTLE_CYCLES = SRC_SETTLE_MS * (CLK_FREQ_HZ / 1000);

  localparam int unsigned CFG_WORDS_DEF    = 16;
  localparam int unsigned INIT_CYCLES      = 8;
  localparam int unsigned SCHEME_W         = 3;

  typedef enum logic [2:0] {
    CMS_SCH_MEMORY      = 3'h0,
    CMS_SCH_SERIAL_PASSIVE_LOAD = 3'h1,
    CMS_SCH_PARALLEL_ASYNC_LOAD = 3'h2,
    CMS_SCH_PARALLEL_SYNC_LOAD  = 3'h3,
    CMS_SCH_SCAN        = 3'h4
  } cms_scheme_e;

  typedef enum logic [2:0] {
    CMS_ST_POR    = 3'h0,
    CMS_ST_WAIT   = 3'h1,
    CMS_ST_LOAD   = 3'h2,
    CMS_ST_INIT   = 3'h3,
    CMS_ST_USER   = 3'h4
  } cms_state_e;

endpackage

// File: cms_sequencer.sv
`timescale 1ns/10ps
module cms_sequencer
  import cms_pkg::*;
#(
  parameter int unsigned POR_CNT   = POR_CYCLES,
  parameter int unsigned RECFG_CNT = RECFG_CYCLES,
  parameter int unsigned CFG_WORDS = CFG_WORDS_DEF
) (
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                reconfig_req_i,
  input  wire logic                chain_enable_in_n_i,
  input  wire logic [SCHEME_W-1:0] scheme_sel_i,
  input  wire logic                cfg_word_valid_i,
  output logic                     cfg_ready_o,
  output logic                     chain_enable_out_n_o,
  output logic                     user_reg_rst_o,
  output logic                     io_enable_o,
  output logic                     io_pullup_o,
  output logic                     command_state_o,
  output logic                     user_state_o,
  output logic                     scheme_err_o,
  output logic                     recfg_overrun_o,
  output logic [SCHEME_W-1:0]      scheme_o
);

  localparam int unsigned CW = $clog2(RECFG_CNT + 1);
  localparam int unsigned WW = $clog2(CFG_WORDS + 1);

  cms_state_e            state_q, state_d;
  logic [CW-1:0]         cnt_q, cnt_d;
  logic [WW-1:0]         words_q, words_d;
  logic [CW-1:0]         recfg_q, recfg_d;
  logic                  recfg_run_q, recfg_run_d;
  logic                  overrun_q, overrun_d;
  logic                  scheme_err_q, scheme_err_d;
  logic [SCHEME_W-1:0]   scheme_q, scheme_d;

  function automatic logic scheme_ok(input logic [SCHEME_W-1:0] s);
    scheme_ok = (s <= SCHEME_W'(CMS_SCH_SCAN));
  endfunction

  // one decode serves both the live state and the next state
  function automatic logic is_command(input cms_state_e s);
    is_command = (s != CMS_ST_USER);
  endfunction

  function automatic logic is_pulled(input cms_state_e s);
    is_pulled = (s == CMS_ST_POR) || (s == CMS_ST_WAIT) || (s == CMS_ST_LOAD);
  endfunction

  wire selected    = ~chain_enable_in_n_i;
  wire legal_sel   = scheme_ok(scheme_sel_i);
  wire por_done    = (cnt_q >= CW'(POR_CNT - 1));
  wire init_done   = (cnt_q >= CW'(INIT_CYCLES - 1));
  wire word_take   = (state_q == CMS_ST_LOAD) && cfg_word_valid_i && selected;
  wire last_word   = word_take && (words_q == WW'(CFG_WORDS - 1));
  wire in_command  = is_command(state_q);
  wire recfg_limit = recfg_run_q && (recfg_q >= CW'(RECFG_CNT - 1));

  // next-state view of the outputs, so each output flop tracks the state
  wire ready_d     = (state_d == CMS_ST_LOAD);
  wire handed_d    = (state_d == CMS_ST_INIT) || (state_d == CMS_ST_USER);
  wire command_d   = is_command(state_d);
  wire user_d      = ~command_d;
  wire pullup_d    = is_pulled(state_d);

  always_comb begin
    state_d      = state_q;
    cnt_d        = cnt_q + CW'(1);
    words_d      = words_q;
    scheme_d     = scheme_q;
    scheme_err_d = scheme_err_q;
    case (state_q)
      CMS_ST_POR: begin
        words_d = '0;
        if (por_done) begin
          state_d = CMS_ST_WAIT;
          cnt_d   = '0;
        end
      end
      CMS_ST_WAIT: begin
        // scheme latched at start of each load, so pins may be shared later
        cnt_d = '0;
        if (selected) begin
          scheme_d     = scheme_sel_i;
          scheme_err_d = ~legal_sel;
          if (legal_sel) begin
            state_d = CMS_ST_LOAD;
          end
        end
      end
      CMS_ST_LOAD: begin
        cnt_d = '0;
        if (word_take) begin
          words_d = words_q + WW'(1);
        end
        if (last_word) begin
          state_d = CMS_ST_INIT;
        end
      end
      CMS_ST_INIT: begin
        if (init_done) begin
          state_d = CMS_ST_USER;
          cnt_d   = '0;
        end
      end
      CMS_ST_USER: begin
        cnt_d = '0;
      end
      default: begin
        state_d = CMS_ST_POR;
        cnt_d   = '0;
      end
    endcase
    // pin-forced reconfiguration overrides any state
    if (reconfig_req_i) begin
      state_d = CMS_ST_WAIT;
      cnt_d   = '0;
      words_d = '0;
    end
  end

  // reconfiguration duration monitor
  always_comb begin
    recfg_run_d = recfg_run_q;
    recfg_d     = recfg_q;
    overrun_d   = overrun_q;
    if (reconfig_req_i) begin
      recfg_run_d = 1'b1;
      recfg_d     = '0;
      overrun_d   = 1'b0;
    end else if (recfg_run_q) begin
      if (!in_command) begin
        recfg_run_d = 1'b0;
      end else if (recfg_limit) begin
        recfg_run_d = 1'b0;
      end else begin
        recfg_d = recfg_q + CW'(1);
      end
    end
    // set wins over a new request, so a late budget miss is never lost
    if (recfg_limit && in_command) begin
      overrun_d = 1'b1;
    end
  end

  // synchronous reset models power-up: state is volatile, always reload
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= CMS_ST_POR;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      words_q <= '0;
    end else begin
      words_q <= words_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scheme_q <= '0;
    end else begin
      scheme_q <= scheme_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scheme_err_q <= 1'b0;
    end else begin
      scheme_err_q <= scheme_err_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      recfg_run_q <= 1'b0;
    end else begin
      recfg_run_q <= recfg_run_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      recfg_q <= '0;
    end else begin
      recfg_q <= recfg_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      overrun_q <= 1'b0;
    end else begin
      overrun_q <= overrun_d;
    end
  end

  // registered outputs, fed from the next state so they change with it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cfg_ready_o <= 1'b0;
    end else begin
      cfg_ready_o <= ready_d;
    end
  end

  // low from init until a reconfig request or reset, so later devices in the chain keep the source
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      chain_enable_out_n_o <= 1'b1;
    end else begin
      chain_enable_out_n_o <= ~handed_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      user_reg_rst_o <= 1'b1;
    end else begin
      user_reg_rst_o <= command_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      io_enable_o <= 1'b0;
    end else begin
      io_enable_o <= user_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      io_pullup_o <= 1'b1;
    end else begin
      io_pullup_o <= pullup_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      command_state_o <= 1'b1;
    end else begin
      command_state_o <= command_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      user_state_o <= 1'b0;
    end else begin
      user_state_o <= user_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scheme_err_o <= 1'b0;
    end else begin
      scheme_err_o <= scheme_err_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      recfg_overrun_o <= 1'b0;
    end else begin
      recfg_overrun_o <= overrun_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scheme_o <= '0;
    end else begin
      scheme_o <= scheme_d;
    end
  end

endmodule

// File: cms_sequencer_props.sv
`timescale 1ns/10ps
module cms_sequencer_props
  import cms_pkg::*;
(
  input wire logic                clk_i,
  input wire logic                sys_rst_i,
  input wire logic                reconfig_req_i,
  input wire logic                cfg_ready_o,
  input wire logic                chain_enable_out_n_o,
  input wire logic                user_reg_rst_o,
  input wire logic                io_enable_o,
  input wire logic                io_pullup_o,
  input wire logic                command_state_o,
  input wire logic                user_state_o,
  input wire logic [SCHEME_W-1:0] scheme_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_hiz; !user_state_o |-> !io_enable_o; endproperty
  a_hiz: assert property (p_hiz) else $error("io on outside user");
  property p_pull; cfg_ready_o |-> io_pullup_o; endproperty
  a_pull: assert property (p_pull) else $error("no pullup in load");
  property p_mode; command_state_o != user_state_o; endproperty
  a_mode: assert property (p_mode) else $error("mode flags clash");
  property p_run; $rose(user_state_o) |-> !user_reg_rst_o && $past(command_state_o); endproperty
  a_run: assert property (p_run) else $error("bad user entry");
  property p_hand; $fell(chain_enable_out_n_o) |-> $past(cfg_ready_o) && !cfg_ready_o; endproperty
  a_hand: assert property (p_hand) else $error("early chain handover");
  property p_init;
    disable iff (sys_rst_i || reconfig_req_i)
    $fell(chain_enable_out_n_o) |-> !user_state_o [*8] ##1 user_state_o;
  endproperty
  a_init: assert property (p_init) else $error("init length wrong");
  property p_recfg; reconfig_req_i |=> command_state_o && !cfg_ready_o && chain_enable_out_n_o; endproperty
  a_recfg: assert property (p_recfg) else $error("reconfig ignored");
  property p_por; $fell(sys_rst_i) |-> !user_state_o [*5]; endproperty
  a_por: assert property (p_por) else $error("user without load");
  property p_sch; $rose(cfg_ready_o) |-> scheme_o <= 3'h4; endproperty
  a_sch: assert property (p_sch) else $error("illegal scheme loads");
endmodule
bind cms_sequencer cms_sequencer_props u_props (.*);

// File: cms_sequencer_tb_top.sv
`timescale 1ns/10ps
module cms_sequencer_tb_top;
  import cms_pkg::*;
  logic clk_i = 0, sys_rst_i = 1, reconfig_req_i = 0, go = 0, stall = 0, up = 0;
  logic chain_enable_in_n_i, cfg_word_valid_i, cfg_ready_o, chain_enable_out_n_o, user_reg_rst_o;
  logic io_enable_o, io_pullup_o, command_state_o, user_state_o, scheme_err_o, recfg_overrun_o;
  logic [SCHEME_W-1:0] scheme_sel_i = '0, scheme_o;
  logic [SCHEME_W-1:0] exp_q[$];
  int miscompares = 0, check_count = 0;
  cms_sequencer #(.POR_CNT(4), .RECFG_CNT(64), .CFG_WORDS(2)) DUT (.clk_i, .sys_rst_i, .reconfig_req_i,
    .chain_enable_in_n_i, .scheme_sel_i, .cfg_word_valid_i, .cfg_ready_o, .chain_enable_out_n_o,
    .user_reg_rst_o, .io_enable_o, .io_pullup_o, .command_state_o, .user_state_o, .scheme_err_o,
    .recfg_overrun_o, .scheme_o);
  cms_src_model SRC (.clk_i, .go_i(go), .ready_i(cfg_ready_o), .stall_i(stall),
    .en_n_o(chain_enable_in_n_i), .valid_o(cfg_word_valid_i));
  initial forever #20 clk_i = ~clk_i;
  always @(negedge clk_i) stall <= $urandom % 2;
  task chk(input logic [7:0] seen, exp, input string nm);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict;
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    up <= user_state_o;
    if (user_state_o === 1'b1 && up === 1'b0) begin
      chk(io_enable_o, 1, "io_enable");
      chk(user_reg_rst_o, 0, "user_reg_rst");
      if (exp_q.size() == 0) chk(0, 1, "extra_user");
      else chk(scheme_o, exp_q.pop_front(), "scheme");
    end
  end
  task run(input logic [2:0] s);
    int n;
    @(negedge clk_i) reconfig_req_i = 1;
    @(negedge clk_i) begin
      reconfig_req_i = 0;
      scheme_sel_i = s;
      go = 1;
    end
    if (s < 5) exp_q.push_back(s);
    // let the source settle and the scheme be sampled before a stale flag is trusted
    repeat (6) @(negedge clk_i);
    for (n = 0; n < 200 && (s > 4 ? scheme_err_o !== 1 : user_state_o !== 1); n++) @(negedge clk_i);
    chk(user_state_o, s < 5, "user");
    chk(scheme_err_o, s > 4, "scheme_err");
    go = 0;
  endtask
  initial begin
    void'($urandom(32'hda58));
    repeat (20) @(negedge clk_i);
    chk({io_enable_o, io_pullup_o, command_state_o}, 3'h3, "reset_out");
    sys_rst_i = 0;
    repeat (10) @(negedge clk_i);
    for (int s = 0; s < 8; s++) run(s);
    repeat (70) @(negedge clk_i);
    chk(recfg_overrun_o, 1, "overrun");
    run(3'h2);
    chk(recfg_overrun_o, 0, "overrun_clr");
    @(negedge clk_i) begin
      reconfig_req_i = 1;
      go = 1;
    end
    @(negedge clk_i) reconfig_req_i = 0;
    for (int n = 0; n < 50 && cfg_ready_o !== 1; n++) @(negedge clk_i);
    @(negedge clk_i) reconfig_req_i = 1;
    @(negedge clk_i) chk({cfg_ready_o, chain_enable_out_n_o}, 1, "abort");
    reconfig_req_i = 0;
    go = 0;
    sys_rst_i = 1;
    repeat (2) @(negedge clk_i);
    chk(user_state_o, 0, "reload");
    sys_rst_i = 0;
    repeat (10) @(negedge clk_i);
    run(3'h4);
    // the watcher pops one edge after the user state shows
    repeat (2) @(negedge clk_i);
    chk(exp_q.size(), 0, "queue");
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    give_verdict();
  end
endmodule

// File: cms_src_model.sv
`timescale 1ns/10ps
module cms_src_model #(
  parameter int SETTLE = 3
) (
  input  wire logic clk_i,
  input  wire logic go_i,
  input  wire logic ready_i,
  input  wire logic stall_i,
  output logic      en_n_o,
  output logic      valid_o
);
  int cnt = 0;
  initial begin
    en_n_o = 1'b1;
    valid_o = 1'b0;
  end
  // settle delay scaled down to keep runs short
  always @(negedge clk_i) begin
    cnt <= go_i ? cnt + 1 : 0;
    en_n_o <= !(go_i && cnt >= SETTLE);
    valid_o <= go_i && ready_i && !stall_i;
  end
endmodule
